// File: hw/tcc_defs.svh
// constants for the timer capture and compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

`define ADDR_CAP1_HI 8'h20
`define ADDR_CAP1_LO 8'h21
`define ADDR_CMP1_HI 8'h22
`define ADDR_CMP1_LO 8'h23
`define ADDR_CAP2_HI 8'h24
`define ADDR_CAP2_LO 8'h25
`define ADDR_CMP2_HI 8'h26
`define ADDR_CMP2_LO 8'h27
`define ADDR_CTRL1 8'h2c
`define ADDR_CTRL2 8'h2d
`define ADDR_STATUS 8'h2e

`define C1_CAP1_IE 7
`define C1_CAP2_IE 6
`define C1_CMP1_IE 5
`define C1_OVF_IE 4
`define C1_CMP1_OE 3
`define C1_EDGE1 2
`define C1_EDGE2 1
`define C1_LVL1 0
`define C2_CMP2_IE 5
`define C2_CMP2_OE 3
`define C2_LVL2 0

`define ST_CAP1F 7
`define ST_CAP2F 6
`define ST_CMP1F 5
`define ST_OVF 4
`define ST_PIN1 3
`define ST_PIN2 2
`define ST_CMP2F 1

`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define CTRL2_MASK 8'h29
`define RDATA_IDLE 8'h00
`define CAP_INC 16'h0001

`endif

// File: hw/tcc_pkg.sv
// types and helpers shared by the capture and compare block
package tcc_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } bus_req_t;

    typedef struct packed {
        logic out_en;
        logic level;
    } cmp_cfg_t;

    function automatic logic next_flag(input logic flag, input logic set, input logic clr);
        return set | (flag & ~clr);
    endfunction

    function automatic logic hit(input bus_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

endpackage

// File: hw/capture_channel.sv
// one input capture channel: pin synchroniser, edge detector, capture latch
`timescale 1ns/10ps
`include "tcc_defs.svh"
module capture_channel import tcc_pkg::*; (
    input logic clk,
    input logic arst_n,
    input logic ce,
    input logic pin,
    input logic rise,
    input logic [15:0] count,
    input logic rd_hi,
    input logic rd_lo,
    output logic [15:0] value,
    output logic level,
    output logic event_pulse
);
    logic s1, s2, s3;
    logic [15:0] c1, c2, c3;
    logic inhibit;
    logic settle;
    logic load;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            c1 <= 16'h0000;
            c2 <= 16'h0000;
            c3 <= 16'h0000;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            // counter delayed alongside the pin so c3 is the value at the sampling edge
            c1 <= count;
            c2 <= c1;
            c3 <= c2;
        end
    end

    assign settle = (s2 == s3) && (s3 != level);
    assign event_pulse = settle && (s3 == rise);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= 1'b0;
        end else if (ce && settle) begin
            level <= s3;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inhibit <= 1'b0;
        end else if (ce) begin
            if (rd_lo) begin
                inhibit <= 1'b0;
            end else if (rd_hi) begin
                inhibit <= 1'b1;
            end
        end
    end

    // the low read lands before the transfer, so it never blocks it
    assign load = event_pulse && (!inhibit || rd_lo);

    // no reset: contents survive reset
    always_ff @(posedge clk) begin
        if (ce && load) begin
            value <= c3 + `CAP_INC;
        end
    end

    property p_cap_load;
        @(posedge clk) disable iff (!arst_n)
        ce && load |=> value == $past(c3) + `CAP_INC;
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture value wrong");

    property p_cap_hold;
        @(posedge clk) disable iff (!arst_n)
        ce && inhibit && !rd_lo |=> $stable(value);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("blocked capture moved");
endmodule

// File: hw/compare_channel.sv
// one output compare channel: 16-bit compare register written a byte at a time, match and pin level
`timescale 1ns/10ps
`include "tcc_defs.svh"
module compare_channel import tcc_pkg::*; (
    input logic clk,
    input logic arst_n,
    input logic ce,
    input logic wr_hi,
    input logic wr_lo,
    input logic [7:0] wdata,
    input logic [15:0] count,
    input logic count_tick,
    input cmp_cfg_t cfg,
    output logic [15:0] value,
    output logic match,
    output logic pin
);
    logic inhibit;

    // no reset and no hardware write: usable as plain storage
    always_ff @(posedge clk) begin
        if (ce) begin
            if (wr_hi) begin
                value[15:8] <= wdata;
            end
            if (wr_lo) begin
                value[7:0] <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inhibit <= 1'b0;
        end else if (ce) begin
            if (wr_lo) begin
                inhibit <= 1'b0;
            end else if (wr_hi) begin
                inhibit <= 1'b1;
            end
        end
    end

    assign match = count_tick && !inhibit && (value == count);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin <= 1'b0;
        end else if (ce && match && cfg.out_en) begin
            pin <= cfg.level;
        end
    end

    property p_cmp_blocked;
        @(posedge clk) disable iff (!arst_n)
        ce && wr_hi && !wr_lo |=> !match;
    endproperty
    a_cmp_blocked: assert property (p_cmp_blocked) else $error("match while inhibited");

    property p_cmp_level;
        @(posedge clk) disable iff (!arst_n)
        ce && match && cfg.out_en |=> pin == $past(cfg.level);
    endproperty
    a_cmp_level: assert property (p_cmp_level) else $error("pin level not taken");

    property p_cmp_byte;
        @(posedge clk) disable iff (!arst_n)
        ce && wr_lo && !wr_hi |=> value[15:8] == $past(value[15:8]);
    endproperty
    a_cmp_byte: assert property (p_cmp_byte) else $error("high byte disturbed");
endmodule

// File: hw/timer_capture_compare.sv
// timer capture and compare block: register decode, flags, status and interrupt
`timescale 1ns/10ps
`include "tcc_defs.svh"
module timer_capture_compare import tcc_pkg::*; (
    input logic CLK,
    input logic ARST_N,
    input logic CE,
    input logic [7:0] ADDR,
    input logic [7:0] WDATA,
    input logic RD,
    input logic WR,
    output logic [7:0] RDATA,
    input logic [15:0] COUNT,
    input logic COUNT_TICK,
    input logic OVERFLOW_FLAG,
    input logic CAPTURE_INPUT_ONE,
    input logic CAPTURE_INPUT_TWO,
    output logic COMPARE_PIN_ONE,
    output logic COMPARE_PIN_TWO,
    output logic TIMER_IRQ
);
    bus_req_t bus;
    logic [7:0] timer_control_one;
    logic [7:0] timer_control_two;
    logic [7:0] status_word;
    logic [7:0] read_word;

    logic rd_status;
    logic rd_cap1_hi;
    logic rd_cap1_lo;
    logic rd_cap2_hi;
    logic rd_cap2_lo;
    logic rd_cmp1_lo;
    logic rd_cmp2_lo;
    logic wr_cmp1_hi;
    logic wr_cmp1_lo;
    logic wr_cmp2_hi;
    logic wr_cmp2_lo;
    logic wr_ctrl1;
    logic wr_ctrl2;

    logic [15:0] cap1_value;
    logic [15:0] cap2_value;
    logic [15:0] cmp1_value;
    logic [15:0] cmp2_value;
    logic [7:0] cap1_high;
    logic cap1_level;
    logic cap2_level;
    logic cap1_evt;
    logic cap2_evt;
    logic cmp1_match;
    logic cmp2_match;
    cmp_cfg_t cmp1_cfg;
    cmp_cfg_t cmp2_cfg;

    logic capture_flag_one;
    logic capture_flag_two;
    logic compare_flag_one;
    logic compare_flag_two;
    logic arm_cap1;
    logic arm_cap2;
    logic arm_cmp1;
    logic arm_cmp2;

    assign bus = '{addr: ADDR, wdata: WDATA, rd: RD, wr: WR};

    // access strobes
    assign rd_status = bus.rd && hit(bus, `ADDR_STATUS);
    assign rd_cap1_hi = bus.rd && hit(bus, `ADDR_CAP1_HI);
    assign rd_cap1_lo = bus.rd && hit(bus, `ADDR_CAP1_LO);
    assign rd_cap2_hi = bus.rd && hit(bus, `ADDR_CAP2_HI);
    assign rd_cap2_lo = bus.rd && hit(bus, `ADDR_CAP2_LO);
    assign rd_cmp1_lo = bus.rd && hit(bus, `ADDR_CMP1_LO);
    assign rd_cmp2_lo = bus.rd && hit(bus, `ADDR_CMP2_LO);
    assign wr_cmp1_hi = bus.wr && hit(bus, `ADDR_CMP1_HI);
    assign wr_cmp1_lo = bus.wr && hit(bus, `ADDR_CMP1_LO);
    assign wr_cmp2_hi = bus.wr && hit(bus, `ADDR_CMP2_HI);
    assign wr_cmp2_lo = bus.wr && hit(bus, `ADDR_CMP2_LO);
    assign wr_ctrl1 = bus.wr && hit(bus, `ADDR_CTRL1);
    assign wr_ctrl2 = bus.wr && hit(bus, `ADDR_CTRL2);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_control_one <= `CTRL1_RST;
        end else if (CE && wr_ctrl1) begin
            timer_control_one <= bus.wdata;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_control_two <= `CTRL2_RST;
        end else if (CE && wr_ctrl2) begin
            timer_control_two <= bus.wdata & `CTRL2_MASK;
        end
    end

    assign cmp1_cfg = '{out_en: timer_control_one[`C1_CMP1_OE],
                        level: timer_control_one[`C1_LVL1]};
    assign cmp2_cfg = '{out_en: timer_control_two[`C2_CMP2_OE],
                        level: timer_control_two[`C2_LVL2]};

    capture_channel u_cap1 (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .pin(CAPTURE_INPUT_ONE),
        .rise(timer_control_one[`C1_EDGE1]),
        .count(COUNT),
        .rd_hi(rd_cap1_hi),
        .rd_lo(rd_cap1_lo),
        .value(cap1_value),
        .level(cap1_level),
        .event_pulse(cap1_evt)
    );

    capture_channel u_cap2 (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .pin(CAPTURE_INPUT_TWO),
        .rise(timer_control_one[`C1_EDGE2]),
        .count(COUNT),
        .rd_hi(rd_cap2_hi),
        .rd_lo(rd_cap2_lo),
        .value(cap2_value),
        .level(cap2_level),
        .event_pulse(cap2_evt)
    );

    compare_channel u_cmp1 (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .wr_hi(wr_cmp1_hi),
        .wr_lo(wr_cmp1_lo),
        .wdata(bus.wdata),
        .count(COUNT),
        .count_tick(COUNT_TICK),
        .cfg(cmp1_cfg),
        .value(cmp1_value),
        .match(cmp1_match),
        .pin(COMPARE_PIN_ONE)
    );

    compare_channel u_cmp2 (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .wr_hi(wr_cmp2_hi),
        .wr_lo(wr_cmp2_lo),
        .wdata(bus.wdata),
        .count(COUNT),
        .count_tick(COUNT_TICK),
        .cfg(cmp2_cfg),
        .value(cmp2_value),
        .match(cmp2_match),
        .pin(COMPARE_PIN_TWO)
    );

    assign cap1_high = cap1_value[15:8];

    // a status read arms each capture and compare flag that is set at that moment; OVERFLOW_FLAG is not armed
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arm_cap1 <= 1'b0;
            arm_cap2 <= 1'b0;
            arm_cmp1 <= 1'b0;
            arm_cmp2 <= 1'b0;
        end else if (CE) begin
            if (rd_status) begin
                arm_cap1 <= capture_flag_one;
                arm_cap2 <= capture_flag_two;
                arm_cmp1 <= compare_flag_one;
                arm_cmp2 <= compare_flag_two;
            end else begin
                if (rd_cap1_lo) begin
                    arm_cap1 <= 1'b0;
                end
                if (rd_cap2_lo) begin
                    arm_cap2 <= 1'b0;
                end
                if (rd_cmp1_lo) begin
                    arm_cmp1 <= 1'b0;
                end
                if (rd_cmp2_lo) begin
                    arm_cmp2 <= 1'b0;
                end
            end
        end
    end

    // a new event in the clearing cycle keeps its flag set
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_flag_one <= 1'b0;
            capture_flag_two <= 1'b0;
            compare_flag_one <= 1'b0;
            compare_flag_two <= 1'b0;
        end else if (CE) begin
            capture_flag_one <= next_flag(capture_flag_one, cap1_evt,
                                          rd_cap1_lo && arm_cap1);
            capture_flag_two <= next_flag(capture_flag_two, cap2_evt,
                                          rd_cap2_lo && arm_cap2);
            compare_flag_one <= next_flag(compare_flag_one, cmp1_match,
                                          rd_cmp1_lo && arm_cmp1);
            compare_flag_two <= next_flag(compare_flag_two, cmp2_match,
                                          rd_cmp2_lo && arm_cmp2);
        end
    end

    always_comb begin
        status_word = `RDATA_IDLE;
        status_word[`ST_CAP1F] = capture_flag_one;
        status_word[`ST_CAP2F] = capture_flag_two;
        status_word[`ST_CMP1F] = compare_flag_one;
        status_word[`ST_OVF] = OVERFLOW_FLAG;
        status_word[`ST_PIN1] = cap1_level;
        status_word[`ST_PIN2] = cap2_level;
        status_word[`ST_CMP2F] = compare_flag_two;
    end

    // high byte at the lower address; capture registers ignore writes
    always_comb begin
        if (bus.addr == `ADDR_CAP1_HI) begin
            read_word = cap1_high;
        end else if (bus.addr == `ADDR_CAP1_LO) begin
            read_word = cap1_value[7:0];
        end else if (bus.addr == `ADDR_CMP1_HI) begin
            read_word = cmp1_value[15:8];
        end else if (bus.addr == `ADDR_CMP1_LO) begin
            read_word = cmp1_value[7:0];
        end else if (bus.addr == `ADDR_CAP2_HI) begin
            read_word = cap2_value[15:8];
        end else if (bus.addr == `ADDR_CAP2_LO) begin
            read_word = cap2_value[7:0];
        end else if (bus.addr == `ADDR_CMP2_HI) begin
            read_word = cmp2_value[15:8];
        end else if (bus.addr == `ADDR_CMP2_LO) begin
            read_word = cmp2_value[7:0];
        end else if (bus.addr == `ADDR_CTRL1) begin
            read_word = timer_control_one;
        end else if (bus.addr == `ADDR_CTRL2) begin
            read_word = timer_control_two;
        end else if (bus.addr == `ADDR_STATUS) begin
            read_word = status_word;
        end else begin
            read_word = `RDATA_IDLE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= `RDATA_IDLE;
        end else if (CE && bus.rd) begin
            RDATA <= read_word;
        end
    end

    assign TIMER_IRQ = (capture_flag_one & timer_control_one[`C1_CAP1_IE])
                     | (capture_flag_two & timer_control_one[`C1_CAP2_IE])
                     | (compare_flag_one & timer_control_one[`C1_CMP1_IE])
                     | (compare_flag_two & timer_control_two[`C2_CMP2_IE])
                     | (OVERFLOW_FLAG & timer_control_one[`C1_OVF_IE]);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    property p_cmp2_set;
        CE && cmp2_match |=> compare_flag_two;
    endproperty
    a_cmp2_set: assert property (p_cmp2_set) else $error("compare flag two not set");

    property p_cmp2_keep;
        CE && compare_flag_two && !arm_cmp2 |=> compare_flag_two;
    endproperty
    a_cmp2_keep: assert property (p_cmp2_keep) else $error("flag two cleared unarmed");

    property p_pin2_status;
        CE && rd_status |=> RDATA[`ST_PIN2] == $past(cap2_level);
    endproperty
    a_pin2_status: assert property (p_pin2_status) else $error("pin two status wrong");

    property p_cap1_set;
        CE && cap1_evt |=> capture_flag_one;
    endproperty
    a_cap1_set: assert property (p_cap1_set) else $error("capture flag one not set");

    property p_cap2_set;
        CE && cap2_evt |=> capture_flag_two;
    endproperty
    a_cap2_set: assert property (p_cap2_set) else $error("capture flag two not set");

    property p_cap1_high;
        CE && rd_cap1_hi |=> RDATA == $past(cap1_high);
    endproperty
    a_cap1_high: assert property (p_cap1_high) else $error("capture high byte wrong");

    property p_cmp1_set;
        CE && cmp1_match |=> compare_flag_one;
    endproperty
    a_cmp1_set: assert property (p_cmp1_set) else $error("compare flag one not set");

    property p_irq_cmp1;
        compare_flag_one && timer_control_one[`C1_CMP1_IE] |-> TIMER_IRQ;
    endproperty
    a_irq_cmp1: assert property (p_irq_cmp1) else $error("no interrupt for compare one");

    property p_match_tick;
        cmp1_match || cmp2_match |-> COUNT_TICK;
    endproperty
    a_match_tick: assert property (p_match_tick) else $error("match off counter step");

    sequence s_arm_cap1;
        CE && rd_status && capture_flag_one;
    endsequence

    sequence s_low_cap1;
        CE && rd_cap1_lo && !cap1_evt;
    endsequence

    property p_cap1_clear;
        s_arm_cap1 ##1 !bus.rd ##1 s_low_cap1 |=> !capture_flag_one;
    endproperty
    a_cap1_clear: assert property (p_cap1_clear) else $error("capture flag one kept");

    sequence s_arm_cmp1;
        CE && rd_status && compare_flag_one;
    endsequence

    sequence s_low_cmp1;
        CE && rd_cmp1_lo && !cmp1_match;
    endsequence

    property p_cmp1_clear;
        s_arm_cmp1 ##1 !bus.rd ##1 s_low_cmp1 |=> !compare_flag_one;
    endproperty
    a_cmp1_clear: assert property (p_cmp1_clear) else $error("compare flag one kept");
endmodule

// File: tb/tcc_far_side.sv
// far side model: free-running counter with divide-by-four prescaler
`timescale 1ns/10ps
module tcc_far_side #(
    parameter logic [15:0] START = 16'hfffc
) (
    input logic clk,
    input logic arst_n,
    output logic [15:0] count,
    output logic count_tick
);
    logic [1:0] pre;

    // tick is high in the first cycle of each new count value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre <= 2'h0;
            count <= START;
            count_tick <= 1'b0;
        end else begin
            pre <= pre + 2'h1;
            count_tick <= (pre == 2'h3);
            if (pre == 2'h3) begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule

// File: tb/timer_capture_compare_bench.sv
// self-checking bench for the timer capture and compare block
`timescale 1ns/10ps
module timer_capture_compare_bench;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic CE = 1'b1;
    logic RD = 1'b0;
    logic WR = 1'b0;
    logic OVERFLOW_FLAG = 1'b0;
    logic CAPTURE_INPUT_ONE = 1'b0;
    logic CAPTURE_INPUT_TWO = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic [15:0] COUNT;
    logic COUNT_TICK;
    logic COMPARE_PIN_ONE;
    logic COMPARE_PIN_TWO;
    logic TIMER_IRQ;
    int miscompares = 0;
    int samples_checked = 0;
    logic [15:0] last_cap;
    logic [15:0] last_cmp;

    always #12.5 CLK = ~CLK;

    tcc_far_side far (.clk(CLK), .arst_n(ARST_N), .count(COUNT), .count_tick(COUNT_TICK));

    timer_capture_compare uut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .ADDR(ADDR),
        .WDATA(WDATA), .RD(RD), .WR(WR), .RDATA(RDATA), .COUNT(COUNT),
        .COUNT_TICK(COUNT_TICK), .OVERFLOW_FLAG(OVERFLOW_FLAG),
        .CAPTURE_INPUT_ONE(CAPTURE_INPUT_ONE), .CAPTURE_INPUT_TWO(CAPTURE_INPUT_TWO),
        .COMPARE_PIN_ONE(COMPARE_PIN_ONE), .COMPARE_PIN_TWO(COMPARE_PIN_TWO),
        .TIMER_IRQ(TIMER_IRQ));

    task automatic final_report;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 8'h01, v[7:0]);
    endtask

    // drive a capture pin; expected capture is the count seen by the first sync flop plus one
    task automatic pin(input int ch, input logic v, output logic [15:0] e);
        @(posedge CLK);
        if (ch == 1) begin
            CAPTURE_INPUT_ONE <= v;
        end else begin
            CAPTURE_INPUT_TWO <= v;
        end
        #1 e = COUNT + 16'h0001;
        repeat (6) @(posedge CLK);
    endtask

    function automatic logic cpin(input int ch);
        return (ch == 1) ? COMPARE_PIN_ONE : COMPARE_PIN_TWO;
    endfunction

    task automatic wait_pin(input int ch, input logic v);
        for (int i = 0; i < 200 && cpin(ch) !== v; i++) @(negedge CLK);
    endtask

    task automatic cap(input int ch);
        logic [7:0] hi, s;
        logic [15:0] e, e2, v;
        hi = (ch == 1) ? 8'h20 : 8'h24;
        wr(8'h2c, (ch == 1) ? 8'h84 : 8'h42);
        pin(ch, 1'b1, e);
        rd(8'h2e, s);
        chk("cap flag", 16'h1, s[8 - ch]);
        chk("input level", 16'h1, s[4 - ch]);
        chk("cap irq", 16'h1, TIMER_IRQ);
        rd16(hi, v);
        chk("cap value", e, v);
        rd(8'h2e, s);
        chk("cap flag clear", 16'h0, s[8 - ch]);
        chk("cap irq clear", 16'h0, TIMER_IRQ);
        rd(hi, s);
        pin(ch, 1'b0, e2);
        rd(8'h2e, s);
        chk("wrong edge", 16'h0, s[8 - ch]);
        pin(ch, 1'b1, e2);
        rd(hi + 8'h01, s);
        chk("blocked low", e[7:0], s);
        rd16(hi, v);
        chk("blocked", e, v);
        // low read alone, flag still set, then a falling-edge capture
        rd(hi + 8'h01, s);
        wr(8'h2c, (ch == 1) ? 8'h80 : 8'h40);
        pin(ch, 1'b0, e2);
        rd16(hi, v);
        chk("latest", e2, v);
        if (ch == 1) begin
            last_cap = e2;
        end
        rd(8'h2e, s);
        rd(hi + 8'h01, s);
    endtask

    task automatic cmp(input int ch);
        logic [7:0] hi, ct, s;
        logic [15:0] t, v;
        int fb;
        hi = (ch == 1) ? 8'h22 : 8'h26;
        ct = (ch == 1) ? 8'h2c : 8'h2d;
        fb = (ch == 1) ? 5 : 1;
        wr(ct, 8'h29);
        wr(hi, 8'h56);
        rd16(hi, v);
        chk("cmp bytes", 16'h5634, v);
        // keep well clear of a high-byte rollover for the next steps
        while (COUNT[7:0] >= 8'h80) @(negedge CLK);
        t = COUNT + 16'h0010;
        wr(hi, t[15:8]);
        rd(8'h2e, s);
        wr(hi + 8'h01, t[7:0]);
        wait_pin(ch, 1'b1);
        chk("cmp pin", 16'h1, cpin(ch));
        rd(8'h2e, s);
        chk("cmp flag", 16'h1, s[fb]);
        chk("cmp irq", 16'h1, TIMER_IRQ);
        rd16(hi, v);
        chk("cmp kept", t, v);
        rd(8'h2e, s);
        chk("cmp flag clear", 16'h0, s[fb]);
        wr(ct, 8'h28);
        while (COUNT[7:0] >= 8'h80) @(negedge CLK);
        t = COUNT + 16'h0010;
        wr(hi, t[15:8]);
        wr(hi + 8'h01, t[7:0]);
        wr(hi, t[15:8]);
        repeat (120) @(posedge CLK);
        rd(8'h2e, s);
        chk("inhibited flag", 16'h0, s[fb]);
        chk("inhibited pin", 16'h1, cpin(ch));
        t = COUNT + 16'h0008;
        wr(hi + 8'h01, t[7:0]);
        wait_pin(ch, 1'b0);
        chk("released pin", 16'h0, cpin(ch));
        wr(ct, 8'h29);
        t = COUNT + 16'h0008;
        wr(hi + 8'h01, t[7:0]);
        wait_pin(ch, 1'b1);
        chk("low only pin", 16'h1, cpin(ch));
        if (ch == 1) begin
            last_cmp = t;
        end
        rd(8'h2e, s);
        rd(hi + 8'h01, s);
    endtask

    task automatic rst_keep;
        logic [15:0] v;
        logic [7:0] s;
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        rd16(8'h20, v);
        chk("cap after reset", last_cap, v);
        rd16(8'h22, v);
        chk("cmp after reset", last_cmp, v);
        wr(8'h20, 8'ha5);
        rd16(8'h20, v);
        chk("cap read only", last_cap, v);
        // a write while the clock enable is low must not land
        @(posedge CLK);
        CE <= 1'b0;
        wr(8'h22, 8'ha5);
        CE <= 1'b1;
        rd16(8'h22, v);
        chk("frozen write", last_cmp, v);
        rd(8'h30, s);
        chk("unmapped", 16'h0, s);
    endtask

    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        final_report;
    end

    initial begin
        repeat (8) @(posedge CLK);
        ARST_N <= 1'b1;
        // high bytes first so no match runs on undefined compare values
        wr(8'h22, 8'h12);
        wr(8'h26, 8'h12);
        wr(8'h23, 8'h34);
        wr(8'h27, 8'h34);
        cmp(1);
        cmp(2);
        cap(1);
        cap(2);
        rst_keep;
        final_report;
    end
endmodule
